// ---- verilog/spi_slices_pkg.sv ----
package spi_slices_pkg;

    // ==================================================================
    // geometry
    localparam int ADDR_W    = 12;
    localparam int PTR_W     = 10;
    localparam int CNT_W     = PTR_W + 1;
    localparam int MEM_DEPTH = 1024;
    localparam int FLAG_W    = 5;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CONTROL      = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_TX_COMMAND   = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_TX_ALARM     = 12'h084;
    localparam logic [ADDR_W-1:0] OFS_TX_STATE     = 12'h088;
    localparam logic [ADDR_W-1:0] OFS_TX_FLAGS     = 12'h08c;
    localparam logic [ADDR_W-1:0] OFS_TX_ENABLE    = 12'h090;
    localparam logic [ADDR_W-1:0] OFS_TX_FILL      = 12'h094;
    localparam logic [ADDR_W-1:0] OFS_TX_POINTER   = 12'h098;
    localparam logic [ADDR_W-1:0] OFS_TX_EXTENT    = 12'h09c;
    localparam logic [ADDR_W-1:0] OFS_TX_WORD      = 12'h0bc;
    localparam logic [ADDR_W-1:0] OFS_RX_COMMAND   = 12'h0c0;
    localparam logic [ADDR_W-1:0] OFS_RX_ALARM     = 12'h0c4;
    localparam logic [ADDR_W-1:0] OFS_RX_STATE     = 12'h0c8;
    localparam logic [ADDR_W-1:0] OFS_RX_FLAGS     = 12'h0cc;
    localparam logic [ADDR_W-1:0] OFS_RX_ENABLE    = 12'h0d0;
    localparam logic [ADDR_W-1:0] OFS_RX_FILL      = 12'h0d4;
    localparam logic [ADDR_W-1:0] OFS_RX_POINTER   = 12'h0d8;
    localparam logic [ADDR_W-1:0] OFS_RX_EXTENT    = 12'h0dc;
    localparam logic [ADDR_W-1:0] OFS_RX_WORD      = 12'h0fc;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_CMD   = 12'hf00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_SUMMARY  = 12'hf04;
    localparam logic [ADDR_W-1:0] OFS_DMA_SUMMARY  = 12'hf08;
    localparam logic [ADDR_W-1:0] OFS_AUX_REQUEST  = 12'hf0c;
    localparam logic [ADDR_W-1:0] OFS_DIAGNOSTIC   = 12'hf10;

    // ==================================================================
    // field positions
    localparam int CMD_RESET_BIT   = 0;
    localparam int CMD_ENABLE_BIT  = 1;
    localparam int FLAG_EMPTY      = 0;
    localparam int FLAG_FULL       = 1;
    localparam int FLAG_ALARM      = 2;
    localparam int FLAG_OVERFLOW   = 3;
    localparam int FLAG_UNDERFLOW  = 4;
    localparam int STATE_EN_BIT    = 8;
    localparam int PTR_RD_LSB      = 0;
    localparam int PTR_WR_LSB      = 16;
    localparam int EXT_START_LSB   = 0;
    localparam int EXT_SIZE_LSB    = 16;
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_WIDTH_LSB  = 1;
    localparam int CTRL_DIV_LSB    = 8;
    localparam int CTRL_DELAY_LSB  = 16;
    localparam int CHANNEL_BIT     = 0;

    // ==================================================================
    // reset values
    localparam logic [31:0]      CONTROL_RESET  = 32'h0000_0300;
    localparam logic [PTR_W-1:0] TX_START_RESET = 10'h000;
    localparam logic [CNT_W-1:0] TX_SIZE_RESET  = 11'h200;
    localparam logic [PTR_W-1:0] RX_START_RESET = 10'h200;
    localparam logic [CNT_W-1:0] RX_SIZE_RESET  = 11'h200;
    localparam logic [CNT_W-1:0] TX_ALARM_RESET = 11'h000;
    localparam logic [CNT_W-1:0] RX_ALARM_RESET = 11'h001;

    // ==================================================================
    // types
    typedef struct packed {
        logic [PTR_W-1:0]  start;
        logic [CNT_W-1:0]  size;
        logic [PTR_W-1:0]  rd;
        logic [PTR_W-1:0]  wr;
        logic [CNT_W-1:0]  count;
        logic              enable;
        logic [CNT_W-1:0]  alarm;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] mask;
    } slice_t;

    typedef struct packed {
        logic cmd;
        logic alarm;
        logic flags;
        logic mask;
        logic ptr;
        logic ext;
    } slice_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b11,
        ST_TRAIL = 2'b10
    } link_state_t;

endpackage

// ---- verilog/spi_channel_fifo_slices.sv ----
// Summary of operation
// - transmit slice registers sit at 0x80, receive slice registers at 0xc0
// - writing a slice command register applies reset and enable to that slice
// - slice state register returns live empty, full, alarm and enable state
// - fill count register reports bytes held, four per stored word
// - pointer register reads and overwrites the read and write pointers
// - extent register holds start location and length in shared memory
// - slice interrupt raised only for flag bits whose enable bit is set
// - interrupt summary shows channels with an interrupt pending
// - DMA summary shows channels with a DMA request pending
// - serial clock driven by master, received by slave
// - master sends 8, 12, 16, 20, 24 or 32 bit words
// - slave returns words of the same configured width
// - only the master asserts slave select to pick its slave
// - one slave select output; more slaves need outside decoding
// - fetch transmit word when shifter empties, push received word when full
// - all slices share one 1024 by 32 memory; software avoids overlap
// - slave select active low; first clock edge follows programmable delay
//
// The APB slave port was decided locally.
module spi_channel_fifo_slices
    import spi_slices_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic                   dma_request,
    input  wire logic              sclk_in,
    output logic                   sclk_out,
    output logic                   sclk_oe,
    input  wire logic              ss_n_in,
    output logic                   ss_n_out,
    output logic                   ss_n_oe,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe
);

    // ==================================================================
    // helpers
    function automatic logic [5:0] width_bits(input logic [2:0] code);
        case (code)
            3'h1:    width_bits = 6'd12;
            3'h2:    width_bits = 6'd16;
            3'h3:    width_bits = 6'd20;
            3'h4:    width_bits = 6'd24;
            3'h5:    width_bits = 6'd32;
            default: width_bits = 6'd8;
        endcase
    endfunction

    // wraps inside the slice's own window of the shared memory
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] start,
                                                  input logic [CNT_W-1:0] size);
        logic [PTR_W-1:0] rel;
        rel = p - start;
        if (({1'b0, rel} + 11'h001) >= size)
            ptr_next = start;
        else
            ptr_next = p + 10'h001;
    endfunction

    function automatic logic alarm_hit(input slice_t s, input logic is_rx);
        alarm_hit = is_rx ? (s.count >= s.alarm) : (s.count <= s.alarm);
    endfunction

    function automatic slice_t slice_step(input slice_t s, input logic is_rx, input slice_wr_t w,
                                          input logic [31:0] d, input logic push, input logic pop);
        slice_t            n;
        logic              empty;
        logic              full;
        logic              do_push;
        logic              do_pop;
        logic [FLAG_W-1:0] ev;
        logic [PTR_W-1:0]  nrd;
        logic [PTR_W-1:0]  nwr;
        n       = s;
        empty   = (s.count == '0);
        full    = (s.count >= s.size);
        do_push = push & ~full;
        do_pop  = pop & ~empty;
        ev      = '0;
        ev[FLAG_EMPTY]     = empty;
        ev[FLAG_FULL]      = full;
        ev[FLAG_ALARM]     = alarm_hit(s, is_rx);
        ev[FLAG_OVERFLOW]  = push & full;
        ev[FLAG_UNDERFLOW] = pop & empty;
        if (do_push)
            n.wr = ptr_next(s.wr, s.start, s.size);
        if (do_pop)
            n.rd = ptr_next(s.rd, s.start, s.size);
        n.count = s.count + CNT_W'(do_push) - CNT_W'(do_pop);
        if (w.alarm)
            n.alarm = d[CNT_W-1:0];
        if (w.mask)
            n.mask = d[FLAG_W-1:0];
        if (w.ext) begin
            n.start = d[EXT_START_LSB +: PTR_W];
            n.size  = d[EXT_SIZE_LSB +: CNT_W];
        end
        if (w.ptr) begin
            nrd     = d[PTR_RD_LSB +: PTR_W];
            nwr     = d[PTR_WR_LSB +: PTR_W];
            n.rd    = nrd;
            n.wr    = nwr;
            n.count = (nwr >= nrd) ? {1'b0, nwr - nrd} : ({1'b0, nwr} + s.size - {1'b0, nrd});
        end
        // set wins over the write-one-to-clear
        n.flags = (s.flags & ~(w.flags ? d[FLAG_W-1:0] : '0)) | ev;
        if (w.cmd) begin
            n.enable = d[CMD_ENABLE_BIT];
            if (d[CMD_RESET_BIT]) begin
                n.rd    = s.start;
                n.wr    = s.start;
                n.count = '0;
                n.flags = '0;
            end
        end
        return n;
    endfunction

    // ==================================================================
    // storage and slice state
    logic [31:0]       mem [MEM_DEPTH];
    slice_t            tx;
    slice_t            rx;
    slice_t            next_tx;
    slice_t            next_rx;
    logic [31:0]       control;
    logic [31:0]       global_cmd;
    logic [31:0]       aux_request;
    logic [31:0]       diagnostic;

    // ==================================================================
    // APB decode
    wire               setup     = psel & ~penable;
    wire               done      = psel & penable & pready;
    wire               wr_done   = done & pwrite;
    wire               rd_done   = done & ~pwrite;
    wire [ADDR_W-1:0]  a         = paddr;
    slice_wr_t         tx_w;
    slice_wr_t         rx_w;
    logic              rx_push_req;
    logic [31:0]       rx_word;
    logic [31:0]       read_mux;
    logic              hit;

    assign tx_w.cmd   = wr_done & (a == OFS_TX_COMMAND);
    assign tx_w.alarm = wr_done & (a == OFS_TX_ALARM);
    assign tx_w.flags = wr_done & (a == OFS_TX_FLAGS);
    assign tx_w.mask  = wr_done & (a == OFS_TX_ENABLE);
    assign tx_w.ptr   = wr_done & (a == OFS_TX_POINTER);
    assign tx_w.ext   = wr_done & (a == OFS_TX_EXTENT);
    assign rx_w.cmd   = wr_done & (a == OFS_RX_COMMAND);
    assign rx_w.alarm = wr_done & (a == OFS_RX_ALARM);
    assign rx_w.flags = wr_done & (a == OFS_RX_FLAGS);
    assign rx_w.mask  = wr_done & (a == OFS_RX_ENABLE);
    assign rx_w.ptr   = wr_done & (a == OFS_RX_POINTER);
    assign rx_w.ext   = wr_done & (a == OFS_RX_EXTENT);

    wire               tx_word_wr = wr_done & (a == OFS_TX_WORD);
    wire               rx_word_rd = rd_done & (a == OFS_RX_WORD);
    wire               tx_full    = (tx.count >= tx.size);
    wire               tx_has     = (tx.count != '0);
    wire               rx_has     = (rx.count != '0);
    wire               rx_full    = (rx.count >= rx.size);

    // one memory write port: a pending receive push stalls the bus a cycle
    assign pready  = ~rx_push_req;
    assign pslverr = done & ~hit;

    // ==================================================================
    // interrupt and request summaries
    wire               tx_irq   = |(tx.flags & tx.mask);
    wire               rx_irq   = |(rx.flags & rx.mask);
    wire               chan_irq = tx_irq | rx_irq;
    wire               chan_dma = (tx.enable & alarm_hit(tx, 1'b0)) | (rx.enable & alarm_hit(rx, 1'b1));
    assign irq         = chan_irq;
    assign dma_request = chan_dma;

    function automatic logic [31:0] state_word(input slice_t s, input logic is_rx);
        logic [31:0] v;
        v                 = '0;
        v[FLAG_EMPTY]     = (s.count == '0);
        v[FLAG_FULL]      = (s.count >= s.size);
        v[FLAG_ALARM]     = alarm_hit(s, is_rx);
        v[STATE_EN_BIT]   = s.enable;
        return v;
    endfunction

    function automatic logic [31:0] ptr_word(input slice_t s);
        logic [31:0] v;
        v                           = '0;
        v[PTR_RD_LSB +: PTR_W]      = s.rd;
        v[PTR_WR_LSB +: PTR_W]      = s.wr;
        return v;
    endfunction

    function automatic logic [31:0] ext_word(input slice_t s);
        logic [31:0] v;
        v                            = '0;
        v[EXT_START_LSB +: PTR_W]    = s.start;
        v[EXT_SIZE_LSB +: CNT_W]     = s.size;
        return v;
    endfunction

    always_comb begin
        hit      = 1'b1;
        read_mux = '0;
        if (a == OFS_CONTROL)
            read_mux = control;
        else if (a == OFS_TX_COMMAND)
            read_mux = {30'h0, tx.enable, 1'b0};
        else if (a == OFS_TX_ALARM)
            read_mux = {21'h0, tx.alarm};
        else if (a == OFS_TX_STATE)
            read_mux = state_word(tx, 1'b0);
        else if (a == OFS_TX_FLAGS)
            read_mux = {27'h0, tx.flags};
        else if (a == OFS_TX_ENABLE)
            read_mux = {27'h0, tx.mask};
        else if (a == OFS_TX_FILL)
            read_mux = {19'h0, tx.count, 2'b00};
        else if (a == OFS_TX_POINTER)
            read_mux = ptr_word(tx);
        else if (a == OFS_TX_EXTENT)
            read_mux = ext_word(tx);
        else if (a == OFS_TX_WORD)
            read_mux = '0;
        else if (a == OFS_RX_COMMAND)
            read_mux = {30'h0, rx.enable, 1'b0};
        else if (a == OFS_RX_ALARM)
            read_mux = {21'h0, rx.alarm};
        else if (a == OFS_RX_STATE)
            read_mux = state_word(rx, 1'b1);
        else if (a == OFS_RX_FLAGS)
            read_mux = {27'h0, rx.flags};
        else if (a == OFS_RX_ENABLE)
            read_mux = {27'h0, rx.mask};
        else if (a == OFS_RX_FILL)
            read_mux = {19'h0, rx.count, 2'b00};
        else if (a == OFS_RX_POINTER)
            read_mux = ptr_word(rx);
        else if (a == OFS_RX_EXTENT)
            read_mux = ext_word(rx);
        else if (a == OFS_RX_WORD)
            read_mux = rx_has ? mem[rx.rd] : '0;
        else if (a == OFS_GLOBAL_CMD)
            read_mux = global_cmd;
        else if (a == OFS_IRQ_SUMMARY)
            read_mux = {31'h0, chan_irq} << CHANNEL_BIT;
        else if (a == OFS_DMA_SUMMARY)
            read_mux = {31'h0, chan_dma} << CHANNEL_BIT;
        else if (a == OFS_AUX_REQUEST)
            read_mux = aux_request;
        else if (a == OFS_DIAGNOSTIC)
            read_mux = diagnostic;
        else
            hit = 1'b0;
    end

    // ==================================================================
    // pin synchronisers
    logic [1:0]        sclk_sync;
    logic [1:0]        ss_sync;
    logic [1:0]        mosi_sync;
    logic [1:0]        miso_sync;
    logic              sclk_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync <= 2'b00;
            ss_sync   <= 2'b11;
            mosi_sync <= 2'b00;
            miso_sync <= 2'b00;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_in};
            ss_sync   <= {ss_sync[0], ss_n_in};
            mosi_sync <= {mosi_sync[0], mosi_in};
            miso_sync <= {miso_sync[0], miso_in};
            sclk_prev <= sclk_sync[1];
        end
    end

    // ==================================================================
    // serial engine
    link_state_t       state;
    link_state_t       next_state;
    logic [31:0]       shreg;
    logic [31:0]       rxreg;
    logic [5:0]        bitcnt;
    logic [7:0]        divcnt;

    wire               master    = control[CTRL_MASTER_BIT];
    wire [5:0]         wbits     = width_bits(control[CTRL_WIDTH_LSB +: 3]);
    wire [7:0]         half_div  = control[CTRL_DIV_LSB +: 8];
    wire [7:0]         lead_div  = control[CTRL_DELAY_LSB +: 8];
    wire               selected  = ~ss_sync[1];
    wire               s_rise    = sclk_sync[1] & ~sclk_prev;
    wire               s_fall    = ~sclk_sync[1] & sclk_prev;
    wire               tick      = (divcnt == 8'h00);
    wire               m_rise    = master & (state == ST_SHIFT) & tick & ~sclk_out;
    wire               m_fall    = master & (state == ST_SHIFT) & tick & sclk_out;
    wire               rise      = master ? m_rise : (s_rise & selected);
    wire               fall      = master ? m_fall : (s_fall & selected);
    wire               sample    = master ? miso_sync[1] : mosi_sync[1];
    wire               last_bit  = fall & (bitcnt == 6'd1);
    wire               m_start   = master & (state == ST_IDLE) & tx.enable & tx_has;
    wire               m_next    = master & (state == ST_TRAIL) & tx.enable & tx_has;
    wire               s_load    = ~master & tx.enable & selected & ((state == ST_IDLE) | last_bit);
    wire               tx_pop    = m_start | m_next | s_load;
    // slave with an empty slice sends zeros; the pop flags the underflow
    wire [31:0]        tx_fetch  = tx_has ? (mem[tx.rd] << (6'd32 - wbits)) : '0;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (m_start)
                    next_state = ST_LEAD;
                else if (s_load)
                    next_state = ST_SHIFT;
            end
            ST_LEAD: begin
                if (tick)
                    next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (!master && !selected)
                    next_state = ST_IDLE;
                else if (master && last_bit)
                    next_state = ST_TRAIL;
            end
            ST_TRAIL: begin
                next_state = m_next ? ST_SHIFT : ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            shreg <= '0;
            rxreg <= '0;
            bitcnt <= '0;
            divcnt <= '0;
            sclk_out <= 1'b0;
            ss_n_out <= 1'b1;
            rx_push_req <= 1'b0;
            rx_word <= '0;
        end else begin
            state <= next_state;
            rx_push_req <= last_bit & rx.enable;
            if (last_bit)
                rx_word <= rxreg;
            if (tx_pop) begin
                shreg  <= tx_fetch;
                rxreg  <= '0;
                bitcnt <= wbits;
            end else if (fall) begin
                shreg  <= {shreg[30:0], 1'b0};
                bitcnt <= bitcnt - 6'd1;
            end
            if (rise)
                rxreg <= {rxreg[30:0], sample};
            if (m_start)
                divcnt <= lead_div;
            else if (tick || state == ST_TRAIL)
                divcnt <= half_div;
            else
                divcnt <= divcnt - 8'h01;
            if (m_rise || m_fall)
                sclk_out <= ~sclk_out;
            if (m_start)
                ss_n_out <= 1'b0;
            else if ((state == ST_TRAIL && !m_next) || !master)
                ss_n_out <= 1'b1;
        end
    end

    // master drives clock, select and data out; slave only answers while selected
    assign sclk_oe  = master;
    assign ss_n_oe  = master;
    assign mosi_oe  = master;
    assign mosi_out = shreg[31];
    assign miso_oe  = ~master & selected;
    assign miso_out = shreg[31];

    // ==================================================================
    // slices, memory and bus registers
    assign next_tx = slice_step(tx, 1'b0, tx_w, pwdata, tx_word_wr, tx_pop);
    assign next_rx = slice_step(rx, 1'b1, rx_w, pwdata, rx_push_req, rx_word_rd);

    always_ff @(posedge pclk) begin
        if (tx_word_wr && !tx_full)
            mem[tx.wr] <= pwdata;
        else if (rx_push_req && !rx_full)
            mem[rx.wr] <= rx_word;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx <= '{start: TX_START_RESET, size: TX_SIZE_RESET, rd: TX_START_RESET, wr: TX_START_RESET,
                   count: '0, enable: 1'b0, alarm: TX_ALARM_RESET, flags: '0, mask: '0};
            rx <= '{start: RX_START_RESET, size: RX_SIZE_RESET, rd: RX_START_RESET, wr: RX_START_RESET,
                   count: '0, enable: 1'b0, alarm: RX_ALARM_RESET, flags: '0, mask: '0};
        end else begin
            tx <= next_tx;
            rx <= next_rx;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control     <= CONTROL_RESET;
            global_cmd  <= '0;
            aux_request <= '0;
            diagnostic  <= '0;
            prdata      <= '0;
        end else begin
            if (setup)
                prdata <= read_mux;
            if (wr_done && a == OFS_CONTROL)
                control <= pwdata;
            if (wr_done && a == OFS_GLOBAL_CMD)
                global_cmd <= pwdata;
            if (wr_done && a == OFS_AUX_REQUEST)
                aux_request <= pwdata;
            if (wr_done && a == OFS_DIAGNOSTIC)
                diagnostic <= pwdata;
        end
    end

endmodule

// ---- bench/spi_slices_asserts.sv ----
// ==========================
// port relations
module spi_slices_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic ss_n_out,
    input wire logic ss_n_oe,
    input wire logic mosi_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
    a_oe_pair: assert property (sclk_oe == ss_n_oe) else $error("oe split");
    a_mosi_drive: assert property (mosi_oe == sclk_oe) else $error("mosi oe");
    a_ss_owner: assert property (!ss_n_out |-> ss_n_oe) else $error("ss undriven");
    a_sclk_frame: assert property (sclk_out |-> !ss_n_out) else $error("clock outside frame");
    a_lead_gap: assert property ($fell(ss_n_out) |-> !sclk_out) else $error("no lead");
    a_push_wait: assert property (!pready |=> pready) else $error("long wait");
    a_half_period: assert property ($rose(sclk_out) |-> sclk_out [*4] ##1 !sclk_out) else $error("half");
endmodule

bind spi_channel_fifo_slices spi_slices_asserts chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .sclk_out, .sclk_oe, .ss_n_out, .ss_n_oe, .mosi_oe);

// ---- bench/spi_peer.sv ----
// ==========================
// far-side slave
module spi_peer (
    input  wire logic sclk,
    input  wire logic ss_n,
    input  wire logic mosi,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] got = 32'h0;
    logic [31:0] out = 32'ha5c3_0000;
    always @(posedge sclk) if (!ss_n) got <= {got[30:0], mosi};
    always @(negedge sclk) if (!ss_n) out <= {out[30:0], ~out[31]};
    // deselected: inverse, so a stale bit never looks valid
    assign miso = ss_n ? ~out[31] : out[31];
endmodule

// ---- bench/spi_channel_fifo_slices_tb.sv ----
// ==========================
// bench top
module spi_channel_fifo_slices_tb import spi_slices_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_request, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              sclk_out, sclk_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe, miso_in;
    wire logic         ss_line = ss_n_oe ? ss_n_out : 1'b1;
    wire logic         sclk_line = sclk_oe & sclk_out;
    int                failures = 0;
    int                num_checks = 0;
    spi_channel_fifo_slices dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .dma_request, .sclk_in(sclk_line), .sclk_out, .sclk_oe, .ss_n_in(ss_line), .ss_n_out,
        .ss_n_oe, .mosi_in(mosi_out), .mosi_out, .mosi_oe, .miso_in, .miso_out(), .miso_oe());
    spi_peer peer_u (.sclk(sclk_line), .ss_n(ss_line), .mosi(mosi_out), .miso(miso_in));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pready and read data taken at the rising edge; returns at the falling edge, outputs settled
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n == 40) failures++;
        if (n == 40) results();
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(negedge pclk);
    endtask
    task rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task t_defaults;
        rchk("control", OFS_CONTROL, CONTROL_RESET);
        rchk("tx extent", OFS_TX_EXTENT, 32'h0200_0000);
        rchk("rx extent", OFS_RX_EXTENT, 32'h0200_0200);
        apb(1'b1, 12'h044, 32'h1);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, OFS_TX_FILL, 32'hc);
        rchk("ro fill", OFS_TX_FILL, 32'h0);
    endtask
    task t_irq;
        apb(1'b1, OFS_TX_COMMAND, 32'h3);
        rchk("tx state", OFS_TX_STATE, 32'h0000_0105);
        chk("dma pin", 32'h1, {31'h0, dma_request});
        rchk("dma sum", OFS_DMA_SUMMARY, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_TX_ENABLE, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk("irq sum", OFS_IRQ_SUMMARY, 32'h1);
        apb(1'b1, OFS_TX_ENABLE, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    task t_transfer;
        int n;
        n = 0;
        apb(1'b1, OFS_RX_COMMAND, 32'h3);
        apb(1'b1, OFS_TX_WORD, 32'h0000_003c);
        rchk("tx fill", OFS_TX_FILL, 32'h4);
        rchk("tx ptr", OFS_TX_POINTER, 32'h0001_0000);
        apb(1'b1, OFS_CONTROL, CONTROL_RESET | 32'h1);
        while (ss_line !== 1'b0 && n < 50) @(negedge pclk) n++;
        if (n >= 50) begin
            failures++;
            results();
        end
        while (ss_line !== 1'b1 && n < 400) @(negedge pclk) n++;
        if (n >= 400) begin
            failures++;
            results();
        end
        chk("mosi", 32'h3c, {24'h0, peer_u.got[7:0]});
        rchk("rx fill", OFS_RX_FILL, 32'h4);
        rchk("rx word", OFS_RX_WORD, 32'h0000_00a5);
        rchk("tx drained", OFS_TX_FILL, 32'h0);
        apb(1'b1, OFS_RX_POINTER, 32'h0203_0201);
        rchk("rx ptr", OFS_RX_POINTER, 32'h0203_0201);
        rchk("ptr fill", OFS_RX_FILL, 32'h8);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_irq();
        t_transfer();
        results();
    end
endmodule
